/* File: bench/cmd_requester.sv */
`timescale 1ns/1ns
`default_nettype none
module cmd_requester (
   input wire logic mclk,
   input wire logic mclk_resetn,
   input wire logic cmd_ack,
   output logic cmd_valid,
   output logic [2:0] cmd_code
);
   logic [2:0] q[$];
   always @(posedge mclk) begin
      if (!mclk_resetn) begin
         cmd_valid <= 1'h0;
         cmd_code <= 3'h0;
      end else if (cmd_valid) begin
         if (cmd_ack) begin
            cmd_valid <= 1'h0;
            cmd_code <= ~cmd_code;
         end
      end else if (q.size() != 0) begin
         cmd_valid <= 1'h1;
         cmd_code <= q.pop_front();
      end else begin
         // idle code wanders so a stale value never looks like a request
         cmd_code <= ~cmd_code;
      end
   end
endmodule
`default_nettype wire

/* File: bench/ddr_sdram_timing_config_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ddr_timing_consts.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module ddr_sdram_timing_config_bench;
   logic aclk = 1'h0, mclk = 1'h0, aresetn = 1'h0, mclk_resetn = 1'h0, mem_generation_strap = 1'h1;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [31:0] m0, m1, lf = 32'hae5eeda0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_valid, cmd_ack, cmd_issue;
   logic [1:0] s_axi_bresp, s_axi_rresp, datapath_latency, write_data_delay, cas_latency_code, die_termination_value;
   logic [2:0] cmd_code, cmd_issued_code, write_recovery_code, ec;
   logic ddr1_selected, narrow_bus, registered_dimm, strobe_single_ended;
   int mismatches = 0, samples_checked = 0, n = 0, t[8] = '{default: -1000};
   int seq[13] = '{1, 2, 3, 2, 4, 1, 1, 5, 5, 4, 1, 3, 4};
   logic [2:0] exp_q[$];

   ddr_sdram_timing_config ddr_sdram_timing_config_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .mem_generation_strap, .mclk, .mclk_resetn, .cmd_valid, .cmd_code, .cmd_ack, .cmd_issue, .cmd_issued_code,
      .datapath_latency, .write_data_delay, .cas_latency_code, .die_termination_value, .write_recovery_code,
      .ddr1_selected, .narrow_bus, .registered_dimm, .strobe_single_ended);
   cmd_requester cmd_requester_i (.mclk, .mclk_resetn, .cmd_ack, .cmd_valid, .cmd_code);

   always #4 aclk = ~aclk;
   initial begin
      #37;
      forever #80 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic bit mapped(input logic [31:0] a);
      return a == 32'h0 || a == 32'h4;
   endfunction
   // minimum spacings in link cycles, measured issue edge to issue edge
   function automatic bit spacing_ok(input logic [2:0] c, input int k);
      int ras, rp, open_to_access_delay, rtc, wtc, rdwr, refresh_cycle_period, rc, wrrd;
      bit ok;
      ras = m0[31:28] + 1;
      rp = m0[26:24] + 1;
      open_to_access_delay = m0[22:20] + 1;
      rtc = m1[30:28];
      wtc = m1[27:24];
      rdwr = (m1[22:20] == 3'h0) ? 8 : m1[22:20];
      refresh_cycle_period = m1[16:12] + 1;
      rc = m1[8:4] + 1;
      wrrd = m1[3:0];
      ok = k - t[4] >= rp;
      foreach (t[i]) ok &= k - t[i] >= 2;
      case (c)
         3'h1: ok &= k - t[1] >= rc && k - t[5] >= refresh_cycle_period;
         3'h2: ok &= k - t[1] >= open_to_access_delay && k - t[3] >= wrrd;
         3'h3: ok &= k - t[1] >= open_to_access_delay && k - t[2] >= rtc && k - t[2] >= rdwr && k - t[3] >= wtc;
         3'h4: ok &= k - t[1] >= ras && k - t[2] >= rtc && k - t[3] >= wtc;
         default: ok &= k - t[1] >= rc && k - t[5] >= refresh_cycle_period && k - t[2] >= rtc && k - t[3] >= wtc;
      endcase
      return ok;
   endfunction

   always @(posedge mclk) begin
      n++;
      if (mclk_resetn && cmd_issue) begin
         ec = exp_q.pop_front();
         `CHK("cmd", ec, cmd_issued_code)
         `CHK("spacing", 1'h1, spacing_ok(cmd_issued_code, n))
         t[cmd_issued_code] = n;
      end
   end

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] bm;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!(s_axi_bready && s_axi_bvalid));
      s_axi_bready <= 1'h0;
      `CHK("bresp", mapped(a) ? `RESP_OKAY : `RESP_SLVERR, s_axi_bresp)
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      if (a == 32'h0) m0 = (m0 & ~(bm & `CTL0_WMASK)) | (d & bm & `CTL0_WMASK);
      if (a == 32'h4) m1 = (m1 & ~(bm & `CTL1_WMASK)) | (d & bm & `CTL1_WMASK);
   endtask
   task automatic reg_rd(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!(s_axi_rready && s_axi_rvalid));
      s_axi_rready <= 1'h0;
      `CHK("rdata", (a == 32'h0) ? m0 : (a == 32'h4) ? m1 : 32'h0, s_axi_rdata)
      `CHK("rresp", mapped(a) ? `RESP_OKAY : `RESP_SLVERR, s_axi_rresp)
   endtask
   task automatic check_cfg;
      `CHK("dp_lat", m0[17:16], datapath_latency)
      `CHK("wr_delay", m0[13:12], write_data_delay)
      `CHK("cas", m0[9:8], cas_latency_code)
      `CHK("odt", m0[5:4], die_termination_value)
      `CHK("gen", m0[2], ddr1_selected)
      `CHK("narrow", m0[1], narrow_bus)
      `CHK("dimm", m0[0], registered_dimm)
      `CHK("strobe", m1[31], strobe_single_ended)
      `CHK("wr_rec", m1[11:9], write_recovery_code)
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      m0 = 32'h0001_0004;
      m1 = 32'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge mclk) mclk_resetn <= 1'h1;
      repeat (8) @(posedge mclk);
      reg_rd(32'h0);
      reg_rd(32'h4);
      check_cfg;
      $display("test reset_values done");
      axi_wr(32'h10, 32'hffff_ffff, 4'hf);
      reg_rd(32'h8);
      axi_wr(32'h4, 32'hffff_ffff, 4'h2);
      reg_rd(32'h4);
      $display("test bus_edges done");
      // first pass is fixed so the zero read-to-write code is always hit
      for (int i = 0; i < 4; i++) begin
         lf = step(lf);
         axi_wr(32'h0, (i == 0) ? 32'h5232_2310 : lf, 4'hf);
         lf = step(lf);
         axi_wr(32'h4, (i == 0) ? 32'hb609_4474 : lf, 4'hf);
         reg_rd(32'h0);
         reg_rd(32'h4);
         repeat (10) @(posedge mclk);
         check_cfg;
         foreach (seq[j]) begin
            exp_q.push_back(seq[j][2:0]);
            cmd_requester_i.q.push_back(seq[j][2:0]);
         end
         for (int w = 0; w < 2000 && exp_q.size() != 0; w++) @(posedge mclk);
         `CHK("left", 0, exp_q.size())
         $display("test config_%0d done", i);
      end
      @(posedge aclk);
      mem_generation_strap <= 1'h0;
      aresetn <= 1'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      m0 = 32'h0001_0000;
      m1 = 32'h0;
      // the link side may first resync its handoff phase, then take the new strap
      repeat (16) @(posedge mclk);
      reg_rd(32'h0);
      reg_rd(32'h4);
      `CHK("gen", 1'h0, ddr1_selected)
      check_cfg;
      $display("test second_reset done");
      finish_test;
   end

   initial begin
      #700000;
      mismatches++;
      finish_test;
   end
endmodule
`default_nettype wire

/* File: bench/ddr_sdram_timing_config_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module ddr_sdram_timing_config_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic mclk,
   input wire logic mclk_resetn,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic cmd_ack,
   input wire logic cmd_issue,
   input wire logic [2:0] cmd_issued_code
);
   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   property p_write_answer;
      @(posedge aclk) disable iff (!aresetn) s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write not answered");
   property p_aw_low;
      @(posedge aclk) disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready;
   endproperty
   a_aw_low: assert property (p_aw_low) else $error("write address open during response");
   property p_b_clear;
      @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_clear: assert property (p_b_clear) else $error("response not withdrawn");
   property p_read_answer;
      @(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_ar_low;
      @(posedge aclk) disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_low: assert property (p_ar_low) else $error("read address open during data");
   // ------------------------------------------------------------
   // command link
   // ------------------------------------------------------------
   property p_ack_issue;
      @(posedge mclk) disable iff (!mclk_resetn)
         cmd_ack || cmd_issue |-> cmd_ack && cmd_issue && cmd_issued_code == cmd_code;
   endproperty
   a_ack_issue: assert property (p_ack_issue) else $error("ack and issue disagree");
   property p_ack_pulse;
      @(posedge mclk) disable iff (!mclk_resetn) cmd_ack |=> !cmd_ack && cmd_issued_code == 3'h0;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("issue longer than one cycle");
   property p_ack_cause;
      @(posedge mclk) disable iff (!mclk_resetn) cmd_ack |-> $past(cmd_valid) && cmd_code inside {[3'h1:3'h5]};
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("issue without request");
endmodule
bind ddr_sdram_timing_config ddr_sdram_timing_config_properties ddr_sdram_timing_config_properties_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .mclk, .mclk_resetn, .cmd_valid, .cmd_code, .cmd_ack, .cmd_issue,
   .cmd_issued_code);
`default_nettype wire

/* File: rtl/ddr_sdram_timing_config.sv */
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ddr_timing_consts.svh"
`default_nettype none

module ddr_sdram_timing_config (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mem_generation_strap,
   input wire logic mclk,
   input wire logic mclk_resetn,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   output logic cmd_ack,
   output logic cmd_issue,
   output logic [2:0] cmd_issued_code,
   output logic [1:0] datapath_latency,
   output logic [1:0] write_data_delay,
   output logic [1:0] cas_latency_code,
   output logic [1:0] die_termination_value,
   output logic [2:0] write_recovery_code,
   output logic ddr1_selected,
   output logic narrow_bus,
   output logic registered_dimm,
   output logic strobe_single_ended
);

   // ------------------------------------------------------------
   // bus clock domain
   // ------------------------------------------------------------
   ddr_timing_pkg::bus_state_t a_r;
   ddr_timing_pkg::bus_state_t a_nxt;
   ddr_timing_pkg::link_state_t m_r;
   ddr_timing_pkg::link_state_t m_nxt;

   always_comb begin
      logic [31:0] bmask;
      logic busy;
      bmask = 32'h0000_0000;
      busy = 1'b0;
      a_nxt = a_r;

      // strap through three flops; wait until the pipe is full before trusting it
      a_nxt.strap_sync = {a_r.strap_sync[1:0], mem_generation_strap};
      if (!a_r.strap_taken) begin
         if (a_r.strap_wait != `STRAP_SETTLE) begin
            a_nxt.strap_wait = a_r.strap_wait + 2'h1;
         end else if (a_r.strap_sync[1] == a_r.strap_sync[2]) begin
            a_nxt.ctl0[`MEMGEN_BIT] = a_r.strap_sync[2];
            a_nxt.strap_taken = 1'b1;
            a_nxt.dirty = 1'b1;
         end
      end

      // write address and data are taken independently, in either order
      if (s_axi_awvalid && a_r.awready) begin
         a_nxt.aw_held = 1'b1;
         a_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && a_r.wready) begin
         a_nxt.w_held = 1'b1;
         a_nxt.wdata = s_axi_wdata;
         a_nxt.wstrb = s_axi_wstrb;
      end
      if (a_r.bvalid && s_axi_bready) begin
         a_nxt.bvalid = 1'b0;
      end
      if (a_r.aw_held && a_r.w_held && !a_r.bvalid) begin
         for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = a_r.wstrb[i] ? 8'hff : 8'h00;
         end
         a_nxt.bvalid = 1'b1;
         a_nxt.aw_held = 1'b0;
         a_nxt.w_held = 1'b0;
         a_nxt.bresp = `RESP_OKAY;
         if (a_r.awaddr[31:2] == `CTL0_OFFSET >> 2) begin
            a_nxt.ctl0 = (a_nxt.ctl0 & ~(bmask & `CTL0_WMASK)) | (a_r.wdata & bmask & `CTL0_WMASK);
            a_nxt.dirty = 1'b1;
         end else if (a_r.awaddr[31:2] == `CTL1_OFFSET >> 2) begin
            a_nxt.ctl1 = (a_r.ctl1 & ~(bmask & `CTL1_WMASK)) | (a_r.wdata & bmask & `CTL1_WMASK);
            a_nxt.dirty = 1'b1;
         end else begin
            a_nxt.bresp = `RESP_SLVERR;
         end
      end

      // read channel
      if (a_r.rvalid && s_axi_rready) begin
         a_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && a_r.arready) begin
         a_nxt.rvalid = 1'b1;
         a_nxt.rresp = `RESP_OKAY;
         if (s_axi_araddr[31:2] == `CTL0_OFFSET >> 2) begin
            a_nxt.rdata = a_r.ctl0;
         end else if (s_axi_araddr[31:2] == `CTL1_OFFSET >> 2) begin
            a_nxt.rdata = a_r.ctl1;
         end else begin
            a_nxt.rdata = 32'h0000_0000;
            a_nxt.rresp = `RESP_SLVERR;
         end
      end
      a_nxt.awready = !a_nxt.aw_held && !a_nxt.bvalid;
      a_nxt.wready = !a_nxt.w_held && !a_nxt.bvalid;
      a_nxt.arready = !a_nxt.rvalid;

      // config handoff: snapshot stays still until the link side acknowledges it;
      // a write during a pending handoff only marks dirty, so the newest value follows
      a_nxt.ack_sync = {a_r.ack_sync[1:0], m_r.seen};
      busy = (a_r.ack_sync[1] != a_r.ack_sync[2]) || (a_r.ack_sync[2] != a_r.req_tgl);
      if (a_r.dirty && !busy) begin
         a_nxt.xfer0 = a_r.ctl0;
         a_nxt.xfer1 = a_r.ctl1;
         a_nxt.req_tgl = !a_r.req_tgl;
         a_nxt.dirty = a_nxt.dirty && (a_nxt.ctl0 != a_r.ctl0 || a_nxt.ctl1 != a_r.ctl1);
      end

      if (!aresetn) begin
         a_nxt = '0;
         a_nxt.ctl0 = `CTL0_RESET;
         a_nxt.ctl1 = `CTL1_RESET;
         a_nxt.xfer0 = `CTL0_RESET;
         a_nxt.xfer1 = `CTL1_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      a_r <= a_nxt;
   end

   // ------------------------------------------------------------
   // memory clock domain: config capture and command spacing
   // ------------------------------------------------------------
   always_comb begin
      logic [5:0] ras_cnt;
      logic [5:0] rp_cnt;
      logic [5:0] rcd_cnt;
      logic [5:0] rc_cnt;
      logic [5:0] rfc_cnt;
      logic [5:0] rd_other_cnt;
      logic [5:0] wr_other_cnt;
      logic [5:0] rd_wr_cnt;
      logic [5:0] wr_rd_cnt;
      logic ok;
      ras_cnt = 6'(m_r.cfg0[`RAS_HI:`RAS_LO]) + `SINCE_ONE;
      rp_cnt = 6'(m_r.cfg0[`RP_HI:`RP_LO]) + `SINCE_ONE;
      rcd_cnt = 6'(m_r.cfg0[`RCD_HI:`RCD_LO]) + `SINCE_ONE;
      rc_cnt = 6'(m_r.cfg1[`RC_HI:`RC_LO]) + `SINCE_ONE;
      rfc_cnt = 6'(m_r.cfg1[`RFC_HI:`RFC_LO]) + `SINCE_ONE;
      rd_other_cnt = 6'(m_r.cfg1[`RD_OTHER_HI:`RD_OTHER_LO]);
      wr_other_cnt = 6'(m_r.cfg1[`WR_OTHER_HI:`WR_OTHER_LO]);
      rd_wr_cnt = (m_r.cfg1[`RD_WR_HI:`RD_WR_LO] == 3'h0) ? `RD_WR_ZERO_CLOCKS :
                  6'(m_r.cfg1[`RD_WR_HI:`RD_WR_LO]);
      wr_rd_cnt = 6'(m_r.cfg1[`WR_RD_HI:`WR_RD_LO]);
      ok = 1'b0;
      m_nxt = m_r;
      m_nxt.cmd_ack = 1'b0;
      m_nxt.cmd_issue = 1'b0;
      m_nxt.cmd_out = ddr_timing_pkg::CMD_NONE;

      // saturating cycle counts since each command kind was issued
      if (m_r.since_act != `SINCE_MAX) m_nxt.since_act = m_r.since_act + `SINCE_ONE;
      if (m_r.since_pre != `SINCE_MAX) m_nxt.since_pre = m_r.since_pre + `SINCE_ONE;
      if (m_r.since_rd != `SINCE_MAX) m_nxt.since_rd = m_r.since_rd + `SINCE_ONE;
      if (m_r.since_wr != `SINCE_MAX) m_nxt.since_wr = m_r.since_wr + `SINCE_ONE;
      if (m_r.since_ref != `SINCE_MAX) m_nxt.since_ref = m_r.since_ref + `SINCE_ONE;

      // handoff request: third and second stages must agree before it counts
      m_nxt.req_sync = {m_r.req_sync[1:0], a_r.req_tgl};
      if (m_r.req_sync[1] == m_r.req_sync[2] && m_r.req_sync[2] != m_r.seen) begin
         m_nxt.cfg0 = a_r.xfer0;
         m_nxt.cfg1 = a_r.xfer1;
         m_nxt.seen = m_r.req_sync[2];
      end

      // every command waits out the close period; then per-kind spacings
      unique case (cmd_code)
         ddr_timing_pkg::CMD_ACTIVATE: begin
            ok = m_r.since_act >= rc_cnt && m_r.since_ref >= rfc_cnt;
         end
         ddr_timing_pkg::CMD_READ: begin
            ok = m_r.since_act >= rcd_cnt && m_r.since_wr >= wr_rd_cnt;
         end
         ddr_timing_pkg::CMD_WRITE: begin
            ok = m_r.since_act >= rcd_cnt && m_r.since_rd >= rd_other_cnt &&
                 m_r.since_rd >= rd_wr_cnt && m_r.since_wr >= wr_other_cnt;
         end
         ddr_timing_pkg::CMD_PRECHARGE: begin
            ok = m_r.since_act >= ras_cnt && m_r.since_rd >= rd_other_cnt &&
                 m_r.since_wr >= wr_other_cnt;
         end
         ddr_timing_pkg::CMD_REFRESH: begin
            ok = m_r.since_act >= rc_cnt && m_r.since_ref >= rfc_cnt &&
                 m_r.since_rd >= rd_other_cnt && m_r.since_wr >= wr_other_cnt;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      ok = ok && m_r.since_pre >= rp_cnt;

      // the cycle after an ack refuses, so a request still held is not taken twice
      if (cmd_valid && !m_r.cmd_ack && ok) begin
         m_nxt.cmd_ack = 1'b1;
         m_nxt.cmd_issue = 1'b1;
         m_nxt.cmd_out = ddr_timing_pkg::cmd_t'(cmd_code);
         unique case (cmd_code)
            ddr_timing_pkg::CMD_ACTIVATE: m_nxt.since_act = `SINCE_ONE;
            ddr_timing_pkg::CMD_READ: m_nxt.since_rd = `SINCE_ONE;
            ddr_timing_pkg::CMD_WRITE: m_nxt.since_wr = `SINCE_ONE;
            ddr_timing_pkg::CMD_PRECHARGE: m_nxt.since_pre = `SINCE_ONE;
            ddr_timing_pkg::CMD_REFRESH: m_nxt.since_ref = `SINCE_ONE;
            default: m_nxt.since_ref = m_nxt.since_ref;
         endcase
      end

      if (!mclk_resetn) begin
         m_nxt = '0;
         m_nxt.cfg0 = `CTL0_RESET;
         m_nxt.cfg1 = `CTL1_RESET;
         m_nxt.since_act = `SINCE_MAX;
         m_nxt.since_pre = `SINCE_MAX;
         m_nxt.since_rd = `SINCE_MAX;
         m_nxt.since_wr = `SINCE_MAX;
         m_nxt.since_ref = `SINCE_MAX;
      end
   end

   always_ff @(posedge mclk) begin
      m_r <= m_nxt;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = a_r.awready;
   assign s_axi_wready = a_r.wready;
   assign s_axi_bvalid = a_r.bvalid;
   assign s_axi_bresp = a_r.bresp;
   assign s_axi_arready = a_r.arready;
   assign s_axi_rvalid = a_r.rvalid;
   assign s_axi_rdata = a_r.rdata;
   assign s_axi_rresp = a_r.rresp;
   assign cmd_ack = m_r.cmd_ack;
   assign cmd_issue = m_r.cmd_issue;
   assign cmd_issued_code = m_r.cmd_out;
   assign datapath_latency = m_r.cfg0[`DP_LAT_HI:`DP_LAT_LO];
   assign write_data_delay = m_r.cfg0[`WDATA_DLY_HI:`WDATA_DLY_LO];
   assign cas_latency_code = m_r.cfg0[`CAS_HI:`CAS_LO];
   assign die_termination_value = m_r.cfg0[`ODT_HI:`ODT_LO];
   assign write_recovery_code = m_r.cfg1[`WR_HI:`WR_LO];
   assign ddr1_selected = m_r.cfg0[`MEMGEN_BIT];
   assign narrow_bus = m_r.cfg0[`WIDTH_BIT];
   assign registered_dimm = m_r.cfg0[`DIMM_BIT];
   assign strobe_single_ended = m_r.cfg1[`STROBE_BIT];

endmodule

`default_nettype wire

/* File: rtl/ddr_timing_consts.svh */
`ifndef DDR_TIMING_CONSTS_SVH
`define DDR_TIMING_CONSTS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CTL0_OFFSET 32'h0000_0000
`define CTL1_OFFSET 32'h0000_0004
`define CTL0_RESET 32'h0001_0000
`define CTL1_RESET 32'h0000_0000
// writable bits; reserved bits and the generation bit read back from hardware
`define CTL0_WMASK 32'hf773_3333
`define CTL1_WMASK 32'hff71_ffff

// ------------------------------------------------------------
// control register zero fields
// ------------------------------------------------------------
`define RAS_HI 31
`define RAS_LO 28
`define RP_HI 26
`define RP_LO 24
`define RCD_HI 22
`define RCD_LO 20
`define DP_LAT_HI 17
`define DP_LAT_LO 16
`define WDATA_DLY_HI 13
`define WDATA_DLY_LO 12
`define CAS_HI 9
`define CAS_LO 8
`define ODT_HI 5
`define ODT_LO 4
`define MEMGEN_BIT 2
`define WIDTH_BIT 1
`define DIMM_BIT 0

// ------------------------------------------------------------
// control register one fields
// ------------------------------------------------------------
`define STROBE_BIT 31
`define RD_OTHER_HI 30
`define RD_OTHER_LO 28
`define WR_OTHER_HI 27
`define WR_OTHER_LO 24
`define RD_WR_HI 22
`define RD_WR_LO 20
`define RFC_HI 16
`define RFC_LO 12
`define WR_HI 11
`define WR_LO 9
`define RC_HI 8
`define RC_LO 4
`define WR_RD_HI 3
`define WR_RD_LO 0

// ------------------------------------------------------------
// timing counts, memory clock cycles; STRAP_SETTLE counts bus clock cycles
// ------------------------------------------------------------
`define SINCE_MAX 6'h3f
`define SINCE_ONE 6'h01
`define RD_WR_ZERO_CLOCKS 6'h08
`define STRAP_SETTLE 2'h3

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: rtl/ddr_timing_pkg.sv */
package ddr_timing_pkg;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ACTIVATE = 3'h1,
      CMD_READ = 3'h2,
      CMD_WRITE = 3'h3,
      CMD_PRECHARGE = 3'h4,
      CMD_REFRESH = 3'h5
   } cmd_t;

   typedef struct packed {
      logic awready;
      logic aw_held;
      logic [31:0] awaddr;
      logic wready;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctl0;
      logic [31:0] ctl1;
      logic [2:0] strap_sync;
      logic [1:0] strap_wait;
      logic strap_taken;
      logic [31:0] xfer0;
      logic [31:0] xfer1;
      logic req_tgl;
      logic dirty;
      logic [2:0] ack_sync;
   } bus_state_t;

   typedef struct packed {
      logic [2:0] req_sync;
      logic seen;
      logic [31:0] cfg0;
      logic [31:0] cfg1;
      logic [5:0] since_act;
      logic [5:0] since_pre;
      logic [5:0] since_rd;
      logic [5:0] since_wr;
      logic [5:0] since_ref;
      logic cmd_ack;
      logic cmd_issue;
      cmd_t cmd_out;
   } link_state_t;

endpackage
